// ===== cfg_opt_pkg.sv
package cfg_opt_pkg;
  localparam logic [7:0] PRIMARY_OFFSET = 8'h40;
  localparam logic [7:0] SECONDARY_OFFSET = 8'h50;
  localparam logic [7:0] POWER_OFFSET = 8'he0;
  localparam logic [31:0] PRIMARY_MASK = 32'he05f_dd7f;
  localparam logic [31:0] SECONDARY_MASK = 32'h003b_f100;
  localparam logic [31:0] POWER_MASK = 32'h0000_0003;
  localparam logic [31:0] PRIMARY_RESET = 32'h0000_0000;
  localparam logic [31:0] SECONDARY_RESET = 32'h0000_b000;
  localparam logic [31:0] POWER_RESET = 32'h0000_0000;
  localparam int CLKSRC_LSB = 0;
  localparam int CLKDIS_BIT = 2;
  localparam int GDIV_BIT = 3;
  localparam int MDIV_BIT = 4;
  localparam int PLLPWR_BIT = 5;
  localparam int PLLSWAP_BIT = 6;
  localparam int VGAIO_BIT = 8;
  localparam int MEMCFG_LSB = 10;
  localparam int HWMASK_BIT = 14;
  localparam int RFH_LSB = 15;
  localparam int ENHREAD_BIT = 22;
  localparam int NORETRY_BIT = 29;
  localparam int ROMEN_BIT = 30;
  localparam int SWAP_BIT = 31;
  localparam int EEWR_BIT = 8;
  localparam int BUFTYPE_LSB = 12;
  localparam int NOGDIV_BIT = 14;
  localparam int NOMDIV_BIT = 15;
  localparam int NOWDIV_BIT = 16;
  localparam int WDIV_BIT = 17;
  localparam int MODCLK_LSB = 19;
  localparam int RFH_SCALE = 64;
  localparam logic [1:0] PS_ON = 2'h0;
  localparam logic [1:0] PS_OFF = 2'h3;
  localparam logic [13:0] SWAP_A_LO = 14'h1c00;
  localparam logic [13:0] SWAP_A_HI = 14'h1eff;
  localparam logic [13:0] SWAP_B_LO = 14'h2000;
  localparam logic [13:0] SWAP_B_HI = 14'h3bff;
  localparam logic [13:0] SWAP_C_LO = 14'h3d00;
  localparam logic [13:0] SWAP_C_HI = 14'h3fff;
  typedef enum logic [2:0] {
    AP_NONE = 3'b000,
    AP_ROM = 3'b001,
    AP_CTRL = 3'b010,
    AP_DMA = 3'b011,
    AP_VGA = 3'b100,
    AP_LINEAR = 3'b101
  } aperture_type;
endpackage

// ===== refresh_if.sv
`timescale 1ns/100ps
`default_nettype none
interface refresh_if;
  logic [5:0] count;
  logic mem_tick;
  logic urgent;
  logic pending;
  logic taken;
  modport timer (input count, input mem_tick, input taken, output urgent, output pending);
  modport owner (output count, output mem_tick, output taken, input urgent, input pending);
endinterface
`default_nettype wire

// ===== refresh_timer.sv
`timescale 1ns/100ps
`default_nettype none
module refresh_timer (
  input wire logic MCLK,
  input wire logic RST,
  refresh_if.timer rf
);
  logic [11:0] ticks;
  logic [11:0] next_ticks;
  logic [1:0] queued;
  logic [1:0] next_queued;
  logic [11:0] limit;

  always_comb begin
    limit = {rf.count, 6'h00};
    next_ticks = ticks;
    next_queued = queued;
    if (rf.count == 6'h00) begin
      // Zero count halts refresh entirely
      next_ticks = 12'h000;
      next_queued = 2'h0;
    end else if (rf.mem_tick) begin
      if (ticks >= limit) begin
        next_ticks = 12'h000;
        // A same-cycle take cancels the new request, so the queue count holds
        if (queued != 2'h2) begin
          next_queued = queued + 2'h1;
        end
        if (rf.taken && queued != 2'h0) begin
          next_queued = queued;
        end
      end else begin
        next_ticks = ticks + 12'h001;
        if (rf.taken && queued != 2'h0) begin
          next_queued = queued - 2'h1;
        end
      end
    end else if (rf.taken && queued != 2'h0) begin
      next_queued = queued - 2'h1;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ticks <= 12'h000;
      queued <= 2'h0;
    end else begin
      ticks <= next_ticks;
      queued <= next_queued;
    end
  end

  assign rf.pending = (queued != 2'h0);
  assign rf.urgent = (queued == 2'h2);
endmodule
`default_nettype wire

// ===== config_option_registers.sv
`timescale 1ns/100ps
`default_nettype none
module config_option_registers (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic SOFT_RST,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  input wire logic [31:0] host_strap_lines,
  input wire logic MEM_REQ,
  input wire logic MEM_WRITE,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [31:0] control_aperture_base,
  input wire logic [31:0] ROM_BASE,
  input wire logic [31:0] pseudo_dma_window,
  input wire logic [31:0] LINEAR_BASE,
  input wire logic VGA_MEM_EN,
  input wire logic VGA_SNOOP,
  input wire logic REFRESH_DONE,
  output logic [31:0] CFG_RDATA,
  output logic [2:0] APERTURE,
  output logic MEM_CLAIM,
  output logic BYTE_SWAP,
  output logic EEPROM_PROGRAM,
  output logic RETRY_ALLOWED,
  output logic READ_LINE_OK,
  output logic [1:0] SYSTEM_CLOCK_SRC,
  output logic SYSTEM_CLOCK_STOP,
  output logic system_pll_power_on,
  output logic PLL_SWAP,
  output logic VGA_IO_DECODE,
  output logic [2:0] MEM_CONFIG,
  output logic HW_PLANE_MASK,
  output logic [1:0] BUFFER_TYPE,
  output logic [2:0] MODULE_CLK_PERIOD,
  output logic graphics_clock,
  output logic MEM_CLOCK,
  output logic ENGINE_CLOCK,
  output logic REFRESH_REQ,
  output logic REFRESH_URGENT
);
  // ---------------------------------------------------------------
  // Option registers
  // ---------------------------------------------------------------
  logic [31:0] primary;
  logic [31:0] secondary;
  logic [1:0] power_state;
  logic [31:0] next_primary;
  logic [31:0] next_secondary;
  logic [1:0] next_power_state;
  logic strap_pending;
  logic [31:0] bmask;

  always_comb begin
    bmask = {{8{CFG_BE[3]}}, {8{CFG_BE[2]}}, {8{CFG_BE[1]}}, {8{CFG_BE[0]}}};
    next_primary = primary;
    next_secondary = secondary;
    next_power_state = power_state;
    if (CFG_WR && CFG_ADDR == cfg_opt_pkg::PRIMARY_OFFSET) begin
      // Reserved bits never store
      next_primary = ((primary & ~bmask) | (CFG_WDATA & bmask)) & cfg_opt_pkg::PRIMARY_MASK;
    end
    if (CFG_WR && CFG_ADDR == cfg_opt_pkg::SECONDARY_OFFSET) begin
      next_secondary = ((secondary & ~bmask) | (CFG_WDATA & bmask))
        & cfg_opt_pkg::SECONDARY_MASK;
    end
    if (CFG_WR && CFG_ADDR == cfg_opt_pkg::POWER_OFFSET && CFG_BE[0]) begin
      // Intermediate states unsupported, so they leave the field alone
      if (CFG_WDATA[1:0] == cfg_opt_pkg::PS_ON || CFG_WDATA[1:0] == cfg_opt_pkg::PS_OFF) begin
        next_power_state = CFG_WDATA[1:0];
      end
    end
    // Straps are caught on the first clock after hard reset release
    if (strap_pending) begin
      next_primary[cfg_opt_pkg::VGAIO_BIT] = host_strap_lines[0];
      next_primary[cfg_opt_pkg::ROMEN_BIT] = host_strap_lines[1];
      next_secondary[cfg_opt_pkg::MODCLK_LSB +: 3] = host_strap_lines[31:29];
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      primary <= cfg_opt_pkg::PRIMARY_RESET;
      secondary <= cfg_opt_pkg::SECONDARY_RESET;
      power_state <= cfg_opt_pkg::POWER_RESET[1:0];
      strap_pending <= 1'b1;
    end else begin
      primary <= next_primary;
      secondary <= next_secondary;
      power_state <= next_power_state;
      strap_pending <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Aperture decode
  // ---------------------------------------------------------------
  cfg_opt_pkg::aperture_type hit;
  logic rom_en;
  logic [13:0] ctrl_off;
  logic swap_range;

  always_comb begin
    rom_en = primary[cfg_opt_pkg::ROMEN_BIT];
    ctrl_off = MEM_ADDR[13:0];
    hit = cfg_opt_pkg::AP_NONE;
    // Lowest priority first so higher hits overwrite
    if (MEM_ADDR[31:24] == LINEAR_BASE[31:24]) begin
      hit = cfg_opt_pkg::AP_LINEAR;
    end
    if (VGA_MEM_EN && MEM_ADDR[31:17] == 15'h0005) begin
      hit = cfg_opt_pkg::AP_VGA;
    end
    if (MEM_ADDR[31:23] == pseudo_dma_window[31:23]) begin
      hit = cfg_opt_pkg::AP_DMA;
    end
    if (MEM_ADDR[31:14] == control_aperture_base[31:14]) begin
      hit = cfg_opt_pkg::AP_CTRL;
    end
    if (rom_en && MEM_ADDR[31:16] == ROM_BASE[31:16]) begin
      hit = cfg_opt_pkg::AP_ROM;
    end
    swap_range = (ctrl_off >= cfg_opt_pkg::SWAP_A_LO && ctrl_off <= cfg_opt_pkg::SWAP_A_HI)
      || (ctrl_off >= cfg_opt_pkg::SWAP_B_LO && ctrl_off <= cfg_opt_pkg::SWAP_B_HI)
      || (ctrl_off >= cfg_opt_pkg::SWAP_C_LO && ctrl_off <= cfg_opt_pkg::SWAP_C_HI);
  end

  // ---------------------------------------------------------------
  // Clock enables from system clock
  // ---------------------------------------------------------------
  // Dividers make one-cycle enables; 3/2 fires two of every three
  logic [1:0] phase;
  logic [1:0] next_phase;
  // Divide by 2 needs its own toggle; the three-phase count is uneven
  logic half;
  logic next_half;
  logic sys_run;
  logic src_ok;
  logic div2;
  logic div15;

  always_comb begin
    src_ok = primary[cfg_opt_pkg::CLKSRC_LSB +: 2] != 2'h3;
    sys_run = src_ok && !primary[cfg_opt_pkg::CLKDIS_BIT]
      && power_state != cfg_opt_pkg::PS_OFF;
    next_phase = phase;
    next_half = half;
    if (sys_run) begin
      next_phase = (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      next_half = !half;
    end
    div2 = sys_run && !half;
    div15 = sys_run && phase != 2'h2;
  end

  function automatic logic pick(input logic run, input logic bypass, input logic sel,
                                input logic d2, input logic d15);
    logic r;
    r = run;
    if (!bypass) begin
      r = sel ? d15 : d2;
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Refresh
  // ---------------------------------------------------------------
  refresh_if rf ();
  logic mem_en;

  always_comb begin
    // The memory divider applies only with the PLL as source
    if (primary[cfg_opt_pkg::CLKSRC_LSB +: 2] == 2'h1) begin
      mem_en = pick(sys_run, secondary[cfg_opt_pkg::NOMDIV_BIT],
                    primary[cfg_opt_pkg::MDIV_BIT], div2, div15);
    end else begin
      mem_en = sys_run;
    end
  end

  assign rf.count = primary[cfg_opt_pkg::RFH_LSB +: 6];
  assign rf.mem_tick = mem_en;
  assign rf.taken = REFRESH_DONE;

  refresh_timer u_refresh (
    .MCLK(MCLK),
    .RST(RST),
    .rf(rf)
  );

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  logic [31:0] rdata;
  logic g_en;
  logic w_en;

  always_comb begin
    rdata = 32'h0000_0000;
    if (CFG_RD) begin
      case (CFG_ADDR)
        cfg_opt_pkg::PRIMARY_OFFSET: rdata = primary;
        cfg_opt_pkg::SECONDARY_OFFSET: rdata = secondary;
        cfg_opt_pkg::POWER_OFFSET: rdata = {30'h0, power_state};
        default: rdata = 32'h0000_0000;
      endcase
    end
    if (primary[cfg_opt_pkg::CLKSRC_LSB +: 2] == 2'h1) begin
      g_en = pick(sys_run, secondary[cfg_opt_pkg::NOGDIV_BIT],
                  primary[cfg_opt_pkg::GDIV_BIT], div2, div15);
    end else begin
      g_en = sys_run;
    end
    w_en = pick(sys_run, secondary[cfg_opt_pkg::NOWDIV_BIT],
                secondary[cfg_opt_pkg::WDIV_BIT], div2, div15);
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      phase <= 2'h0;
      half <= 1'b0;
      CFG_RDATA <= 32'h0000_0000;
      APERTURE <= 3'h0;
      MEM_CLAIM <= 1'b0;
      BYTE_SWAP <= 1'b0;
      EEPROM_PROGRAM <= 1'b0;
      RETRY_ALLOWED <= 1'b1;
      READ_LINE_OK <= 1'b0;
      SYSTEM_CLOCK_SRC <= 2'h0;
      SYSTEM_CLOCK_STOP <= 1'b0;
      system_pll_power_on <= 1'b0;
      PLL_SWAP <= 1'b0;
      VGA_IO_DECODE <= 1'b0;
      MEM_CONFIG <= 3'h0;
      HW_PLANE_MASK <= 1'b0;
      BUFFER_TYPE <= 2'h0;
      MODULE_CLK_PERIOD <= 3'h0;
      graphics_clock <= 1'b0;
      MEM_CLOCK <= 1'b0;
      ENGINE_CLOCK <= 1'b0;
      REFRESH_REQ <= 1'b0;
      REFRESH_URGENT <= 1'b0;
    end else begin
      phase <= next_phase;
      half <= next_half;
      CFG_RDATA <= rdata;
      APERTURE <= MEM_REQ ? hit : cfg_opt_pkg::AP_NONE;
      MEM_CLAIM <= MEM_REQ && hit != cfg_opt_pkg::AP_NONE;
      // Config space is never swapped; only control aperture ranges
      BYTE_SWAP <= MEM_REQ && hit == cfg_opt_pkg::AP_CTRL && swap_range
        && primary[cfg_opt_pkg::SWAP_BIT];
      EEPROM_PROGRAM <= MEM_REQ && MEM_WRITE && hit == cfg_opt_pkg::AP_ROM
        && secondary[cfg_opt_pkg::EEWR_BIT];
      RETRY_ALLOWED <= !primary[cfg_opt_pkg::NORETRY_BIT] || VGA_SNOOP;
      READ_LINE_OK <= primary[cfg_opt_pkg::ENHREAD_BIT];
      SYSTEM_CLOCK_SRC <= primary[cfg_opt_pkg::CLKSRC_LSB +: 2];
      SYSTEM_CLOCK_STOP <= !sys_run;
      system_pll_power_on <= primary[cfg_opt_pkg::PLLPWR_BIT]
        && power_state != cfg_opt_pkg::PS_OFF;
      PLL_SWAP <= primary[cfg_opt_pkg::PLLSWAP_BIT];
      VGA_IO_DECODE <= primary[cfg_opt_pkg::VGAIO_BIT];
      MEM_CONFIG <= primary[cfg_opt_pkg::MEMCFG_LSB +: 3];
      HW_PLANE_MASK <= primary[cfg_opt_pkg::HWMASK_BIT];
      BUFFER_TYPE <= secondary[cfg_opt_pkg::BUFTYPE_LSB +: 2];
      MODULE_CLK_PERIOD <= secondary[cfg_opt_pkg::MODCLK_LSB +: 3];
      graphics_clock <= g_en;
      MEM_CLOCK <= mem_en;
      ENGINE_CLOCK <= w_en;
      REFRESH_REQ <= rf.pending;
      REFRESH_URGENT <= rf.urgent;
    end
  end
endmodule
`default_nettype wire

// ===== cfg_opt_chk.sv
`timescale 1ns/100ps
`default_nettype none
module cfg_opt_chk (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [31:0] CFG_RDATA,
  input wire logic MEM_REQ,
  input wire logic MEM_WRITE,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [31:0] control_aperture_base,
  input wire logic VGA_SNOOP,
  input wire logic [2:0] APERTURE,
  input wire logic MEM_CLAIM,
  input wire logic BYTE_SWAP,
  input wire logic EEPROM_PROGRAM,
  input wire logic RETRY_ALLOWED,
  input wire logic SYSTEM_CLOCK_STOP,
  input wire logic graphics_clock,
  input wire logic MEM_CLOCK,
  input wire logic REFRESH_REQ,
  input wire logic REFRESH_URGENT
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  sequence s_rd_pri;
    CFG_RD && CFG_ADDR == cfg_opt_pkg::PRIMARY_OFFSET;
  endsequence
  // Three cycles allow for the gate's own register stage
  sequence s_stopped;
    SYSTEM_CLOCK_STOP [*3];
  endsequence
  a_rsv_read_zero: assert property (
    s_rd_pri |=> (CFG_RDATA & ~cfg_opt_pkg::PRIMARY_MASK) == 32'h0)
    else $error("reserved option bits read back nonzero");
  a_idle_no_claim: assert property (
    !MEM_REQ |=> !MEM_CLAIM && APERTURE == cfg_opt_pkg::AP_NONE)
    else $error("claim without a memory request");
  a_claim_needs_hit: assert property (MEM_CLAIM |-> APERTURE != cfg_opt_pkg::AP_NONE)
    else $error("claim with no aperture hit");
  a_ctrl_over_linear: assert property (
    APERTURE == cfg_opt_pkg::AP_LINEAR |->
    $past(MEM_ADDR[31:14]) != $past(control_aperture_base[31:14]))
    else $error("linear decode hides control aperture");
  a_swap_ctrl_only: assert property (BYTE_SWAP |-> APERTURE == cfg_opt_pkg::AP_CTRL)
    else $error("byte swap outside control aperture");
  a_eeprom_rom_write: assert property (
    EEPROM_PROGRAM |-> APERTURE == cfg_opt_pkg::AP_ROM && $past(MEM_WRITE))
    else $error("eeprom program without rom write");
  a_snoop_retry: assert property (VGA_SNOOP |=> RETRY_ALLOWED)
    else $error("retry blocked during snoop");
  a_urgent_queued: assert property (REFRESH_URGENT |-> REFRESH_REQ)
    else $error("urgent refresh with nothing queued");
  a_stop_clocks: assert property (s_stopped |-> !graphics_clock && !MEM_CLOCK)
    else $error("clock enables while system clock stopped");
endmodule
bind config_option_registers cfg_opt_chk cfg_opt_chk_inst (.MCLK, .RST, .CFG_RD,
  .CFG_ADDR, .CFG_RDATA, .MEM_REQ, .MEM_WRITE, .MEM_ADDR, .control_aperture_base, .VGA_SNOOP,
  .APERTURE, .MEM_CLAIM, .BYTE_SWAP, .EEPROM_PROGRAM, .RETRY_ALLOWED, .SYSTEM_CLOCK_STOP,
  .graphics_clock, .MEM_CLOCK, .REFRESH_REQ, .REFRESH_URGENT);
`default_nettype wire

// ===== host_bridge_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_bridge_model (
  input wire logic MCLK,
  input wire logic [31:0] CFG_RDATA,
  output logic CFG_WR,
  output logic CFG_RD,
  output logic [7:0] CFG_ADDR,
  output logic [3:0] CFG_BE,
  output logic [31:0] CFG_WDATA
);
  // ----------------------------------------
  // Configuration cycles
  // ----------------------------------------
  initial begin
    CFG_WR = 1'b0;
    CFG_RD = 1'b0;
    CFG_ADDR = 8'h00;
    CFG_BE = 4'h0;
    CFG_WDATA = 32'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge MCLK);
    CFG_ADDR = a;
    CFG_BE = be;
    CFG_WDATA = d;
    CFG_WR = 1'b1;
    @(negedge MCLK);
    CFG_WR = 1'b0;
    // Stale data inverted so a late sample cannot pass
    CFG_WDATA = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge MCLK);
    CFG_ADDR = a;
    CFG_RD = 1'b1;
    @(negedge MCLK);
    CFG_RD = 1'b0;
    d = CFG_RDATA;
  endtask
endmodule
`default_nettype wire

// ===== config_option_registers_tb.sv
`timescale 1ns/100ps
`default_nettype none
module config_option_registers_tb;
  logic MCLK, RST, SOFT_RST, MEM_REQ, MEM_WRITE, VGA_MEM_EN, VGA_SNOOP, REFRESH_DONE;
  logic CFG_WR, CFG_RD, MEM_CLAIM, BYTE_SWAP, EEPROM_PROGRAM, RETRY_ALLOWED, READ_LINE_OK;
  logic SYSTEM_CLOCK_STOP, system_pll_power_on, PLL_SWAP, VGA_IO_DECODE, HW_PLANE_MASK;
  logic graphics_clock, MEM_CLOCK, ENGINE_CLOCK, REFRESH_REQ, REFRESH_URGENT, es, ee, er;
  logic [7:0] CFG_ADDR;
  logic [3:0] CFG_BE, be;
  logic [1:0] SYSTEM_CLOCK_SRC, BUFFER_TYPE;
  logic [2:0] APERTURE, MEM_CONFIG, MODULE_CLK_PERIOD, ea;
  logic [31:0] CFG_WDATA, CFG_RDATA, host_strap_lines, MEM_ADDR, control_aperture_base;
  logic [31:0] ROM_BASE, pseudo_dma_window, LINEAR_BASE, pri, sec, lf, rv, bm;
  int n_mismatch, n_checks, t;
  config_option_registers config_option_registers_inst (.MCLK, .RST, .SOFT_RST, .CFG_WR,
    .CFG_RD, .CFG_ADDR, .CFG_BE, .CFG_WDATA, .host_strap_lines, .MEM_REQ, .MEM_WRITE,
    .MEM_ADDR, .control_aperture_base, .ROM_BASE, .pseudo_dma_window, .LINEAR_BASE,
    .VGA_MEM_EN, .VGA_SNOOP, .REFRESH_DONE, .CFG_RDATA, .APERTURE, .MEM_CLAIM, .BYTE_SWAP,
    .EEPROM_PROGRAM, .RETRY_ALLOWED, .READ_LINE_OK, .SYSTEM_CLOCK_SRC, .SYSTEM_CLOCK_STOP,
    .system_pll_power_on, .PLL_SWAP, .VGA_IO_DECODE, .MEM_CONFIG, .HW_PLANE_MASK,
    .BUFFER_TYPE, .MODULE_CLK_PERIOD, .graphics_clock, .MEM_CLOCK, .ENGINE_CLOCK,
    .REFRESH_REQ, .REFRESH_URGENT);
  host_bridge_model host_bridge_model_inst (.MCLK, .CFG_RDATA, .CFG_WR, .CFG_RD, .CFG_ADDR,
    .CFG_BE, .CFG_WDATA);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0);
  endfunction
  function automatic logic [2:0] exp_ap(input logic [31:0] a);
    if (pri[30] && a[31:16] == ROM_BASE[31:16]) return cfg_opt_pkg::AP_ROM;
    if (a[31:14] == control_aperture_base[31:14]) return cfg_opt_pkg::AP_CTRL;
    if (a[31:23] == pseudo_dma_window[31:23]) return cfg_opt_pkg::AP_DMA;
    if (VGA_MEM_EN && a[31:17] == 15'h0005) return cfg_opt_pkg::AP_VGA;
    if (a[31:24] == LINEAR_BASE[31:24]) return cfg_opt_pkg::AP_LINEAR;
    return cfg_opt_pkg::AP_NONE;
  endfunction
  function automatic logic in_swap(input logic [13:0] o);
    return (o >= 14'h1c00 && o <= 14'h1eff) || (o >= 14'h2000 && o <= 14'h3bff) ||
      o >= 14'h3d00;
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic rd_cmp(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    host_bridge_model_inst.rd(a, d);
    cmp_word(d, exp);
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
    input logic [31:0] exp);
    host_bridge_model_inst.wr(a, b, d);
    rd_cmp(a, exp);
  endtask
  task automatic chk_cfg;
    @(negedge MCLK);
    cmp_word({30'h0, SYSTEM_CLOCK_SRC}, {30'h0, pri[1:0]});
    cmp_bit(SYSTEM_CLOCK_STOP, pri[2]);
    cmp_bit(system_pll_power_on, pri[5]);
    cmp_bit(PLL_SWAP, pri[6]);
    cmp_bit(VGA_IO_DECODE, pri[8]);
    cmp_word({29'h0, MEM_CONFIG}, {29'h0, pri[12:10]});
    cmp_bit(HW_PLANE_MASK, pri[14]);
    cmp_bit(READ_LINE_OK, pri[22]);
    cmp_word({30'h0, BUFFER_TYPE}, {30'h0, sec[13:12]});
    cmp_word({29'h0, MODULE_CLK_PERIOD}, {29'h0, sec[21:19]});
  endtask
  task automatic run_mem(input int n);
    for (int i = 0; i <= n; i++) begin
      @(negedge MCLK);
      if (i > 0) begin
        cmp_word({29'h0, APERTURE}, {29'h0, ea});
        cmp_bit(MEM_CLAIM, ea != 3'h0);
        cmp_bit(BYTE_SWAP, es);
        cmp_bit(EEPROM_PROGRAM, ee);
        cmp_bit(RETRY_ALLOWED, er);
      end
      lf = lfsr(lf);
      MEM_ADDR = lf;
      if (lf[31]) MEM_ADDR[31:24] = 8'h10;
      if (lf[30]) MEM_ADDR[23:15] = 9'h0;
      if (lf[29] && lf[28]) MEM_ADDR = {15'h0005, lf[16:0]};
      MEM_REQ = (i < n) && (lf[27] || lf[26]);
      MEM_WRITE = lf[25];
      VGA_MEM_EN = lf[24];
      VGA_SNOOP = lf[23];
      ea = MEM_REQ ? exp_ap(MEM_ADDR) : 3'h0;
      es = ea == cfg_opt_pkg::AP_CTRL && pri[31] && in_swap(MEM_ADDR[13:0]);
      ee = ea == cfg_opt_pkg::AP_ROM && MEM_WRITE && sec[8];
      er = !pri[29] || VGA_SNOOP;
    end
  endtask
  task automatic pulses(input int g, input int m, input int e);
    int cg, cm, ce;
    cg = 0;
    cm = 0;
    ce = 0;
    repeat (12) begin
      @(negedge MCLK);
      cg += int'(graphics_clock === 1'b1);
      cm += int'(MEM_CLOCK === 1'b1);
      ce += int'(ENGINE_CLOCK === 1'b1);
    end
    cmp_word(32'(cg), 32'(g));
    cmp_word(32'(cm), 32'(m));
    cmp_word(32'(ce), 32'(e));
  endtask
  task automatic watch(input logic urg, input int lim, input logic must, output int n);
    n = 0;
    while (n < lim && (urg ? REFRESH_URGENT : REFRESH_REQ) !== 1'b1) begin
      @(negedge MCLK);
      n++;
    end
    if (must && n >= lim) begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic pulse_done;
    @(negedge MCLK);
    REFRESH_DONE = 1'b1;
    @(negedge MCLK);
    REFRESH_DONE = 1'b0;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    RST = 1'b1;
    SOFT_RST = 1'b0;
    MEM_REQ = 1'b0;
    MEM_WRITE = 1'b0;
    MEM_ADDR = 32'h0;
    VGA_MEM_EN = 1'b0;
    VGA_SNOOP = 1'b0;
    REFRESH_DONE = 1'b0;
    lf = 32'h9c3a_8a7a;
    host_strap_lines = lf;
    control_aperture_base = 32'h1000_4000;
    ROM_BASE = 32'h1000_0000;
    pseudo_dma_window = 32'h1000_0000;
    LINEAR_BASE = 32'h1000_0000;
    n_mismatch = 0;
    n_checks = 0;
    repeat (4) @(negedge MCLK);
    RST = 1'b0;
    pri = {1'b0, lf[1], 21'h0, lf[0], 8'h0};
    sec = {10'h0, lf[31:29], 19'h0_b000};
    rd_cmp(cfg_opt_pkg::PRIMARY_OFFSET, pri);
    rd_cmp(cfg_opt_pkg::SECONDARY_OFFSET, sec);
    rd_cmp(cfg_opt_pkg::POWER_OFFSET, 32'h0);
    rd_cmp(8'h44, 32'h0);
    for (int i = 0; i < 16; i++) begin
      lf = lfsr(lf);
      // Host keeps reserved bits zero, except the first deliberate write of all ones but bit 1
      rv = (i == 0) ? 32'hffff_fffd : lf & (lf[0] ? cfg_opt_pkg::PRIMARY_MASK : 32'h003b_f100);
      if (rv[1:0] == 2'h3) rv[1] = 1'b0;
      be = (i == 0) ? 4'hf : lf[7:4];
      bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      if (lf[0]) begin
        pri = (pri & ~bm) | (rv & bm & cfg_opt_pkg::PRIMARY_MASK);
        wr_rd(cfg_opt_pkg::PRIMARY_OFFSET, be, rv, pri);
      end else begin
        sec = (sec & ~bm) | (rv & bm & cfg_opt_pkg::SECONDARY_MASK);
        wr_rd(cfg_opt_pkg::SECONDARY_OFFSET, be, rv, sec);
      end
      chk_cfg();
      run_mem(8);
    end
    for (int v = 1; v < 3; v++) begin
      host_bridge_model_inst.wr(cfg_opt_pkg::POWER_OFFSET, 4'h1, 32'(v));
      rd_cmp(cfg_opt_pkg::POWER_OFFSET, 32'h0);
    end
    wr_rd(cfg_opt_pkg::POWER_OFFSET, 4'h1, 32'h3, 32'h3);
    repeat (3) @(negedge MCLK);
    cmp_bit(SYSTEM_CLOCK_STOP, 1'b1);
    cmp_bit(system_pll_power_on, 1'b0);
    host_bridge_model_inst.wr(cfg_opt_pkg::POWER_OFFSET, 4'h1, 32'h0);
    pri = 32'h0000_0031;
    wr_rd(cfg_opt_pkg::PRIMARY_OFFSET, 4'hf, pri, pri);
    sec = (sec & 32'hfffc_3fff) | 32'h0002_0000;
    wr_rd(cfg_opt_pkg::SECONDARY_OFFSET, 4'hf, sec, sec);
    pulses(6, 8, 8);
    sec = sec | 32'h0001_c000;
    wr_rd(cfg_opt_pkg::SECONDARY_OFFSET, 4'hf, sec, sec);
    pulses(12, 12, 12);
    pri = 32'h0000_0020;
    wr_rd(cfg_opt_pkg::PRIMARY_OFFSET, 4'hf, pri, pri);
    repeat (2) pulse_done();
    watch(1'b0, 150, 1'b0, t);
    cmp_word(32'(t), 32'd150);
    pri = 32'h0000_8020;
    wr_rd(cfg_opt_pkg::PRIMARY_OFFSET, 4'hf, pri, pri);
    watch(1'b0, 100, 1'b1, t);
    watch(1'b1, 100, 1'b1, t);
    cmp_bit(t >= 63 && t <= 67, 1'b1);
    pulse_done();
    // Urgent flag trails the served pulse by one register stage
    @(negedge MCLK);
    cmp_bit(REFRESH_URGENT, 1'b0);
    cmp_bit(REFRESH_REQ, 1'b1);
    results();
  end
endmodule
`default_nettype wire
